// ---- core/vpd_params.svh ----
/*
 Offsets, field positions and reset values for the oscillator,
 loop and divider configuration bank.
 Assumes byte-wide registers on an 8-bit register address.
*/
`ifndef VPD_PARAMS_SVH
`define VPD_PARAMS_SVH

// Register offsets
`define VPD_OFS_CALCFG   8'h0e
`define VPD_OFS_AMP      8'h0f
`define VPD_OFS_BAND     8'h10
`define VPD_OFS_RSVD     8'h11
`define VPD_OFS_FBHI     8'h12
`define VPD_OFS_FBMID    8'h13
`define VPD_OFS_FBLO     8'h14
`define VPD_OFS_FIRSTHI  8'h15
`define VPD_OFS_SHARED   8'h16
`define VPD_OFS_SECLO    8'h17
`define VPD_OFS_THIRD    8'h18

// Single-bit field positions
`define VPD_B_CALGO      7
`define VPD_B_LVLAUTO    6
`define VPD_B_CALMAN     2
`define VPD_B_BOOST      1
`define VPD_B_BANDMAN    0
`define VPD_B_FBSRC      3
`define VPD_B_OUTSRC     2
`define VPD_B_LOOPRST    0
`define VPD_B_TESTEN     3

// Multi-bit field ranges inside a register
`define VPD_F_THR        5:3
`define VPD_F_AMP        7:2
`define VPD_F_BAND       7:1
`define VPD_F_NIB_HI     7:4
`define VPD_F_FIRST_LO   7:6
`define VPD_F_SEC_HI     5:0
`define VPD_F_TSEL       2:1
`define VPD_F_THIRD      7:5
// Slices of the wide divider values
`define VPD_N_HI         19:12
`define VPD_N_MID        11:4
`define VPD_N_LO         3:0
`define VPD_D_HI8        9:2
`define VPD_D_LO2        1:0
`define VPD_D_HI6        9:4
`define VPD_D_LO4        3:0

// Reset values
`define VPD_RST_THR      3'h6
`define VPD_RST_AMP      6'h20
`define VPD_RST_BAND     7'h40
`define VPD_RST_FBDIV    20'h80000
`define VPD_RST_FIRST    10'h080
`define VPD_RST_SECOND   10'h000
`define VPD_RST_THIRD    3'h1

// Third divider: code k divides by k plus this offset
`define VPD_THIRD_BASE   4'h4
`define VPD_THIRD_BAD    3'h0

// Test select codes for the lock pin
`define VPD_TS_XTAL      2'h0
`define VPD_TS_UP        2'h1
`define VPD_TS_REF       2'h2
`define VPD_TS_FB        2'h3

`endif

// ---- core/vpd_pkg.sv ----
/*
 Types for the oscillator, loop and divider configuration bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package vpd_pkg;

    // One register access from the serial port deserialiser
    typedef struct packed {
        logic [7:0] addr;   // Register offset
        logic [7:0] data;   // Write data
        logic       wr;     // Write strobe, one cycle
        logic       rd;     // Read strobe, one cycle
    } vpd_regreq_t;

    // A full set of divider values
    typedef struct packed {
        logic [19:0] fbDiv;     // Feedback divider
        logic [9:0]  firstDiv;  // First output divider
        logic [9:0]  secondDiv; // Second output divider
        logic [2:0]  thirdDiv;  // Third output divider code
    } vpd_divset_t;

    // Software visible configuration
    typedef struct packed {
        logic        calManual;
        logic        levelAuto;
        logic [2:0]  levelThr;
        logic        supplyBoost;
        logic        bandManual;
        logic [5:0]  amplitude;
        logic [6:0]  band;
        vpd_divset_t div;
        logic        fbFromReg;
        logic        outFromReg;
        logic        loopReset;
        logic        testPortEn;
        logic [1:0]  testSel;
    } vpd_cfg_t;

    // Whole state of the bank
    typedef struct packed {
        vpd_cfg_t    cfg;
        logic        calStart;
        logic [7:0]  rdData;
        logic        rdValid;
        vpd_divset_t eff;
        logic [3:0]  thirdRatio;
        logic        thirdInvalid;
        logic        lockPin;
    } vpd_state_t;

endpackage

// ---- core/vpd_regs.sv ----
/*
 Oscillator, loop and divider configuration bank.
 Assumes register accesses arrive as one-cycle strobes on clk_sys
 from the serial port logic; preset divider values come from the
 pin decode table on the same clock; lock and test clocks are async.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vpd_params.svh"

// Function
// - Calibrate bit starts calibration, self-clears, gated
// - Manual calibration bit disables automatic calibration
// - Level enable picks automatic or fixed amplitude
// - Three-bit level threshold, reset 110
// - Boost bit raises oscillator supply
// - Manual band bit selects band field
// - Amplitude field bits 7:2, reset 10 0000
// - Band field seven bits, reset 100 0000
// - Feedback divider split over three registers
// - Feedback divider resets 0x80000, gated by source
// - Feedback source: pins preset or register
// - Output source: pins or divider registers
// - Loop reset spares the output dividers
// - First divider split, reset 128
// - Second divider split across two registers
// - Test port off: pin shows lock
// - Test select picks lock pin source
// - Third divider codes 1..7 divide 5..11
module vpd_regs (
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    input  wire vpd_pkg::vpd_regreq_t regReq,
    input  wire vpd_pkg::vpd_divset_t presetDiv,
    input  wire logic                 lockDetect,
    input  wire logic                 xtalClk,
    input  wire logic                 pumpUpHalf,
    input  wire logic                 refHalf,
    input  wire logic                 fbHalf,
    output logic               [7:0]  regRdData,
    output logic                      regRdValid,
    output logic                      calStart,
    output logic                      calManual,
    output logic                      levelAuto,
    output logic               [2:0]  levelThreshold,
    output logic               [5:0]  vcoAmplitude,
    output logic                      supplyBoost,
    output logic                      bandManual,
    output logic               [6:0]  vcoBand,
    output vpd_pkg::vpd_divset_t      divSetting,
    output logic               [3:0]  thirdDivRatio,
    output logic                      thirdDivInvalid,
    output logic                      loopReset,
    output logic                      lockPin
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    logic                rstN;      // Reset, released synchronously
    logic [4:0]          asyncSync; // Synchronised async levels
    logic                lockSync;  // Loop lock status
    logic                xtalSync;  // Crystal oscillator output
    logic                upSync;    // Pump-up clock halved
    logic                refSync;   // Reference clock halved
    logic                fbSync;    // Feedback clock halved
    vpd_pkg::vpd_state_t st;        // Registered state
    vpd_pkg::vpd_state_t next_st;   // Next state

    ////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers

    // Reset asserts at once and leaves after two clean edges
    vpd_sync #(.W(1)) uRstSync (
        .clk_sys (clk_sys),
        .rstN    (nrst),
        .d       (1'b1),
        .q       (rstN)
    );

    // Test clocks are sampled at 40 MHz, so the pin only shows
    // them faithfully while they stay well below that rate
    vpd_sync #(.W(5)) uPinSync (
        .clk_sys (clk_sys),
        .rstN    (rstN),
        .d       ({lockDetect, xtalClk, pumpUpHalf, refHalf, fbHalf}),
        .q       (asyncSync)
    );

    assign {lockSync, xtalSync, upSync, refSync, fbSync} = asyncSync;

    ////////////////////////////////////////////////////////////////////
    // Read-back of one register from the configuration

    function automatic logic [7:0] regRead(
        input vpd_pkg::vpd_cfg_t c,
        input logic [7:0]        a
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `VPD_OFS_CALCFG:
            begin
                // Calibrate bit is self-clearing, reads zero
                v[`VPD_B_LVLAUTO] = c.levelAuto;
                v[`VPD_F_THR]     = c.levelThr;
                v[`VPD_B_CALMAN]  = c.calManual;
                v[`VPD_B_BOOST]   = c.supplyBoost;
                v[`VPD_B_BANDMAN] = c.bandManual;
            end
            `VPD_OFS_AMP:     v[`VPD_F_AMP] = c.amplitude;
            `VPD_OFS_BAND:    v[`VPD_F_BAND] = c.band;
            `VPD_OFS_FBHI:    v = c.div.fbDiv[`VPD_N_HI];
            `VPD_OFS_FBMID:   v = c.div.fbDiv[`VPD_N_MID];
            `VPD_OFS_FBLO:
            begin
                v[`VPD_F_NIB_HI]  = c.div.fbDiv[`VPD_N_LO];
                v[`VPD_B_FBSRC]   = c.fbFromReg;
                v[`VPD_B_OUTSRC]  = c.outFromReg;
                v[`VPD_B_LOOPRST] = c.loopReset;
            end
            `VPD_OFS_FIRSTHI: v = c.div.firstDiv[`VPD_D_HI8];
            `VPD_OFS_SHARED:
            begin
                v[`VPD_F_FIRST_LO] = c.div.firstDiv[`VPD_D_LO2];
                v[`VPD_F_SEC_HI]   = c.div.secondDiv[`VPD_D_HI6];
            end
            `VPD_OFS_SECLO:
            begin
                v[`VPD_F_NIB_HI] = c.div.secondDiv[`VPD_D_LO4];
                v[`VPD_B_TESTEN] = c.testPortEn;
                v[`VPD_F_TSEL]   = c.testSel;
            end
            `VPD_OFS_THIRD:   v[`VPD_F_THIRD] = c.div.thirdDiv;
            default:          v = 8'h00;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        next_st          = st;
        next_st.calStart = 1'b0;
        next_st.rdValid  = regReq.rd;
        next_st.rdData   = regReq.rd ? regRead(st.cfg, regReq.addr)
                                     : st.rdData;

        // Writes; bits with no field and offset reserved_pll_slot are dropped
        if (regReq.wr)
        begin
            unique case (regReq.addr)
                `VPD_OFS_CALCFG:
                begin
                    next_st.cfg.calManual = regReq.data[`VPD_B_CALMAN];
                    next_st.cfg.levelAuto = regReq.data[`VPD_B_LVLAUTO];
                    next_st.cfg.levelThr = regReq.data[`VPD_F_THR];
                    next_st.cfg.supplyBoost = regReq.data[`VPD_B_BOOST];
                    next_st.cfg.bandManual = regReq.data[`VPD_B_BANDMAN];
                    next_st.calStart = regReq.data[`VPD_B_CALGO]
                                     & regReq.data[`VPD_B_CALMAN];
                end
                `VPD_OFS_AMP:
                    next_st.cfg.amplitude = regReq.data[`VPD_F_AMP];
                `VPD_OFS_BAND:
                    next_st.cfg.band = regReq.data[`VPD_F_BAND];
                `VPD_OFS_FBHI:
                    next_st.cfg.div.fbDiv[`VPD_N_HI] = regReq.data;
                `VPD_OFS_FBMID:
                    next_st.cfg.div.fbDiv[`VPD_N_MID] = regReq.data;
                `VPD_OFS_FBLO:
                begin
                    next_st.cfg.div.fbDiv[`VPD_N_LO] =
                        regReq.data[`VPD_F_NIB_HI];
                    next_st.cfg.fbFromReg = regReq.data[`VPD_B_FBSRC];
                    next_st.cfg.outFromReg = regReq.data[`VPD_B_OUTSRC];
                    next_st.cfg.loopReset = regReq.data[`VPD_B_LOOPRST];
                end
                `VPD_OFS_FIRSTHI:
                    next_st.cfg.div.firstDiv[`VPD_D_HI8] = regReq.data;
                `VPD_OFS_SHARED:
                begin
                    next_st.cfg.div.firstDiv[`VPD_D_LO2] =
                        regReq.data[`VPD_F_FIRST_LO];
                    next_st.cfg.div.secondDiv[`VPD_D_HI6] =
                        regReq.data[`VPD_F_SEC_HI];
                end
                `VPD_OFS_SECLO:
                begin
                    next_st.cfg.div.secondDiv[`VPD_D_LO4] =
                        regReq.data[`VPD_F_NIB_HI];
                    next_st.cfg.testPortEn = regReq.data[`VPD_B_TESTEN];
                    next_st.cfg.testSel = regReq.data[`VPD_F_TSEL];
                end
                `VPD_OFS_THIRD:
                    next_st.cfg.div.thirdDiv = regReq.data[`VPD_F_THIRD];
                default:
                    next_st.cfg = st.cfg;
            endcase
        end

        // output dividers source, all three together
        next_st.eff = st.cfg.outFromReg ? st.cfg.div : presetDiv;

        // feedback divider source, independent of the outputs
        next_st.eff.fbDiv = st.cfg.fbFromReg ? st.cfg.div.fbDiv
                                             : presetDiv.fbDiv;

        // third divider ratio; code 000 flagged, ratio zero
        next_st.thirdInvalid = (st.eff.thirdDiv == `VPD_THIRD_BAD);
        next_st.thirdRatio   = next_st.thirdInvalid ? 4'h0
                             : {1'b0, st.eff.thirdDiv} + `VPD_THIRD_BASE;

        // lock status unless test port is on
        next_st.lockPin = lockSync;
        if (st.cfg.testPortEn)
        begin
            unique case (st.cfg.testSel)
                `VPD_TS_XTAL: next_st.lockPin = xtalSync;
                `VPD_TS_UP:   next_st.lockPin = upSync;
                `VPD_TS_REF:  next_st.lockPin = refSync;
                `VPD_TS_FB:   next_st.lockPin = fbSync;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register; reset values of every field

    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            st                    <= '0;
            st.cfg.levelAuto      <= 1'b1;
            st.cfg.levelThr       <= `VPD_RST_THR;
            st.cfg.amplitude      <= `VPD_RST_AMP;
            st.cfg.band           <= `VPD_RST_BAND;
            st.cfg.div.fbDiv      <= `VPD_RST_FBDIV;
            st.cfg.div.firstDiv   <= `VPD_RST_FIRST;
            st.cfg.div.secondDiv  <= `VPD_RST_SECOND;
            st.cfg.div.thirdDiv   <= `VPD_RST_THIRD;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign regRdData       = st.rdData;
    assign regRdValid      = st.rdValid;
    assign calStart        = st.calStart;
    assign calManual       = st.cfg.calManual;
    assign levelAuto       = st.cfg.levelAuto;
    assign levelThreshold  = st.cfg.levelThr;
    assign vcoAmplitude    = st.cfg.amplitude;
    assign supplyBoost     = st.cfg.supplyBoost;
    assign bandManual      = st.cfg.bandManual;
    assign vcoBand         = st.cfg.band;
    assign divSetting      = st.eff;
    assign thirdDivRatio   = st.thirdRatio;
    assign thirdDivInvalid = st.thirdInvalid;
    assign loopReset       = st.cfg.loopReset;
    assign lockPin         = st.lockPin;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstN);

    cal_start_gate_a: assert property (
        regReq.wr && regReq.addr == `VPD_OFS_CALCFG
        |=> calStart == ($past(regReq.data[`VPD_B_CALGO])
                         && $past(regReq.data[`VPD_B_CALMAN]))
    ) else $error("calibration start not gated correctly");
    // A write taken during the pulse may legally start another one
    cal_self_clear_a: assert property (
        calStart |-> calManual ##1 (!calStart || $past(regReq.wr))
    ) else $error("calibration start not a single manual pulse");
    level_mode_a: assert property (
        regReq.wr && regReq.addr == `VPD_OFS_CALCFG
        |=> levelAuto == $past(regReq.data[`VPD_B_LVLAUTO])
    ) else $error("level mode bit not taken");
    fb_source_a: assert property (
        !st.cfg.fbFromReg && $stable(presetDiv.fbDiv)
        |=> divSetting.fbDiv == $past(presetDiv.fbDiv)
    ) else $error("feedback divider not from preset");
    fb_register_a: assert property (
        st.cfg.fbFromReg ##1 st.cfg.fbFromReg
        |-> divSetting.fbDiv == $past(st.cfg.div.fbDiv)
    ) else $error("feedback divider not from register");
    out_source_a: assert property (
        !st.cfg.outFromReg
        |=> divSetting.firstDiv == $past(presetDiv.firstDiv)
            && divSetting.secondDiv == $past(presetDiv.secondDiv)
    ) else $error("output dividers not from preset");
    third_ratio_a: assert property (
        divSetting.thirdDiv == 3'h1 |=> thirdDivRatio == 4'h5
    ) else $error("third divider ratio wrong");
    loop_reset_a: assert property (
        regReq.wr && regReq.addr == `VPD_OFS_FBLO
        |=> loopReset == $past(regReq.data[`VPD_B_LOOPRST])
    ) else $error("loop reset bit not taken");
    lock_status_a: assert property (
        !st.cfg.testPortEn |=> lockPin == $past(lockSync)
    ) else $error("lock pin not showing lock status");
    test_xtal_a: assert property (
        st.cfg.testPortEn && st.cfg.testSel == `VPD_TS_XTAL
        |=> lockPin == $past(xtalSync)
    ) else $error("test port not showing crystal");
    unused_read_a: assert property (
        regReq.rd && regReq.addr == `VPD_OFS_RSVD
        |=> regRdValid && regRdData == 8'h00
    ) else $error("unused register read not zero");

endmodule // vpd_regs

`default_nettype wire

// ---- core/vpd_sync.sv ----
/*
 Two flip-flop synchroniser, a bus of independent levels.
 Assumes each bit is a level; bits are not coherent with each other.
*/
`timescale 1ns/1ps
`default_nettype none

module vpd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rstN,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // First stage, read only by the second
    logic [W-1:0] meta;

    ////////////////////////////////////////////////////////////////////
    // Two stages, cleared asynchronously
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // vpd_sync

`default_nettype wire

// ---- sim/test_vco_pll_divider_control_regs.sv ----
/*
 Self-checking bench for the oscillator, loop and divider bank.
 Assumes the bank's one-cycle strobe register port on clk_sys and
 drives the preset dividers and the async lock and test inputs itself.
*/
`timescale 1ns/1ps
`default_nettype none

module test_vco_pll_divider_control_regs;

    logic                 clk_sys;         // 40 MHz system clock
    logic                 nrst;            // Async reset, active low
    vpd_pkg::vpd_regreq_t regReq;          // Register access strobes
    vpd_pkg::vpd_divset_t presetDiv;       // Pin preset divider values
    logic                 lockDetect;      // Loop lock status
    logic [3:0]           testIn;          // Feedback, ref, pump-up, xtal
    logic [7:0]           regRdData;       // Read data
    logic                 regRdValid;      // Read answer strobe
    logic                 calStart;        // Calibration start pulse
    logic                 calManual;       // Manual calibration mode
    logic                 levelAuto;       // Automatic amplitude
    logic [2:0]           levelThreshold;  // Level detector threshold
    logic [5:0]           vcoAmplitude;    // Fixed amplitude
    logic                 supplyBoost;     // Raised supply
    logic                 bandManual;      // Manual band mode
    logic [6:0]           vcoBand;         // Fixed band
    vpd_pkg::vpd_divset_t divSetting;      // Effective dividers
    logic [3:0]           thirdDivRatio;   // Third divider ratio
    logic                 thirdDivInvalid; // Third code is 000
    logic                 loopReset;       // Loop logic reset
    logic                 lockPin;         // Lock indicator pin
    int                   mismatches;      // Failed comparisons
    int                   n_tests;         // All comparisons
    int                   cycles;          // Clock count for timeout
    logic [7:0]           rstTab [13];     // Reset bytes, 0x0d..0x19

    vpd_regs u_dut (
        .clk_sys         (clk_sys),
        .nrst            (nrst),
        .regReq          (regReq),
        .presetDiv       (presetDiv),
        .lockDetect      (lockDetect),
        .xtalClk         (testIn[0]),
        .pumpUpHalf      (testIn[1]),
        .refHalf         (testIn[2]),
        .fbHalf          (testIn[3]),
        .regRdData       (regRdData),
        .regRdValid      (regRdValid),
        .calStart        (calStart),
        .calManual       (calManual),
        .levelAuto       (levelAuto),
        .levelThreshold  (levelThreshold),
        .vcoAmplitude    (vcoAmplitude),
        .supplyBoost     (supplyBoost),
        .bandManual      (bandManual),
        .vcoBand         (vcoBand),
        .divSetting      (divSetting),
        .thirdDivRatio   (thirdDivRatio),
        .thirdDivInvalid (thirdDivInvalid),
        .loopReset       (loopReset),
        .lockPin         (lockPin)
    );

    ////////////////////////////////////////////////////////////////////
    // Clock, timeout and reporting

    // Free running clock, 25 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Prints the counts and the verdict, then stops
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // A hang is cut short well past the fewer than two hundred cycles needed
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Port tasks

    // Case-equality compare, so an unknown only matches an unknown
    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string msg);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask

    // Waits n edges, ending just after an edge
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask

    // One-cycle write strobe; a leading edge keeps strobes apart
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        idle(1);
        regReq.addr = a;
        regReq.data = d;
        regReq.wr   = 1'b1;
        regReq.rd   = 1'b0;
        idle(1);
        regReq.wr   = 1'b0;
    endtask

    // One-cycle read strobe; answer is checked in its only cycle
    task automatic regRead(input logic [7:0] a, input logic [7:0] exp);
        idle(1);
        regReq.addr = a;
        regReq.rd   = 1'b1;
        regReq.wr   = 1'b0;
        idle(1);
        chk(regRdValid, 1'b1, "read valid");
        chk(regRdData, exp, "read data");
        regReq.rd   = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence

    initial
    begin
        nrst       = 1'b0;
        regReq     = '0;
        presetDiv  = '{fbDiv: 20'h0abcd, firstDiv: 10'h155,
                      secondDiv: 10'h0aa, thirdDiv: 3'h3};
        lockDetect = 1'b0;
        testIn     = 4'h0;
        mismatches = 0;
        n_tests    = 0;
        cycles     = 0;
        rstTab     = '{8'h00, 8'h70, 8'h80, 8'h80, 8'h00, 8'h80, 8'h00,
                      8'h00, 8'h20, 8'h00, 8'h00, 8'h20, 8'h00};
        idle(4);
        nrst = 1'b1;
        idle(4);
        // Reset levels at the outputs
        chk({calManual, levelAuto}, 2'h1, "cal lvl");
        chk({supplyBoost, bandManual}, 2'h0, "boost band");
        chk(levelThreshold, 3'h6, "threshold");
        chk({vcoAmplitude, vcoBand}, {6'h20, 7'h40}, "amp band");
        chk(divSetting, presetDiv, "preset dividers");
        chk(thirdDivRatio, 4'h7, "preset ratio");
        chk(loopReset, 1'b0, "loop reset");
        // Reset bytes, with unmapped neighbours at both ends
        for (int i = 0; i < 13; i++)
        begin
            regRead(8'(8'h0d + i), rstTab[i]);
        end
        // Calibrate bit ignored without manual mode, then pulses
        regWrite(8'h0e, 8'h80);
        chk(calStart, 1'b0, "cal gated");
        regWrite(8'h0e, 8'h84);
        chk({calStart, calManual, levelAuto}, 3'h6, "cal go");
        chk(levelThreshold, 3'h0, "threshold min");
        idle(1);
        chk(calStart, 1'b0, "cal self clear");
        regRead(8'h0e, 8'h04);
        regWrite(8'h0e, 8'h7b);
        chk({calManual, levelAuto}, 2'h1, "cal lvl");
        chk({supplyBoost, bandManual}, 2'h3, "boost band");
        chk(levelThreshold, 3'h7, "threshold max");
        regRead(8'h0e, 8'h7b);
        // Amplitude and band at full scale, unused low bits
        regWrite(8'h0f, 8'hff);
        regWrite(8'h10, 8'hff);
        chk({vcoAmplitude, vcoBand}, {6'h3f, 7'h7f}, "amp band");
        regRead(8'h0f, 8'hfc);
        regRead(8'h10, 8'hfe);
        // Writes to the unused slot and past the bank vanish
        regWrite(8'h11, 8'hff);
        regWrite(8'h19, 8'hff);
        regRead(8'h11, 8'h00);
        regRead(8'h19, 8'h00);
        // Divider registers ignored while pins are the source
        regWrite(8'h12, 8'h12);
        regWrite(8'h13, 8'h34);
        regWrite(8'h14, 8'h50);
        regWrite(8'h15, 8'ha9);
        regWrite(8'h16, 8'h5c);
        regWrite(8'h17, 8'h30);
        regWrite(8'h18, 8'he0);
        idle(3);
        chk(divSetting, presetDiv, "pins still rule");
        // Feedback from registers only; unused bit 1 dropped
        regWrite(8'h14, 8'h5a);
        idle(3);
        chk(divSetting.fbDiv, 20'h12345, "fb split");
        chk(divSetting.firstDiv, presetDiv.firstDiv, "out pins");
        regRead(8'h14, 8'h58);
        // Output source on, loop reset on: dividers keep values
        regWrite(8'h14, 8'h5d);
        idle(3);
        chk(loopReset, 1'b1, "loop reset set");
        chk(divSetting, {20'h12345, 10'h2a5, 10'h1c3, 3'h7}, "dv");
        chk(divSetting.firstDiv, 10'h2a5, "first");
        chk(divSetting.secondDiv, 10'h1c3, "second");
        // Every third divider code, 000 flagged
        for (int k = 0; k < 8; k++)
        begin
            regWrite(8'h18, {3'(k), 5'h1f});
            idle(3);
            chk(thirdDivInvalid, k == 0, "third invalid");
            chk(thirdDivRatio, (k == 0) ? 0 : k + 4, "ratio");
            regRead(8'h18, {3'(k), 5'h00});
        end
        // Test port off: pin follows lock status
        lockDetect = 1'b1;
        idle(3);
        chk(lockPin, 1'b1, "lock high");
        lockDetect = 1'b0;
        idle(3);
        chk(lockPin, 1'b0, "lock low");
        // Test port on: each source, lock held opposite
        for (int s = 0; s < 4; s++)
        begin
            regWrite(8'h17, 8'(8'h38 | (s << 1)));
            lockDetect = 1'b0;
            testIn = 4'(4'h1 << s);
            idle(3);
            chk(lockPin, 1'b1, "test source high");
            lockDetect = 1'b1;
            testIn = ~4'(4'h1 << s);
            idle(3);
            chk(lockPin, 1'b0, "test source low");
        end
        final_report();
    end

endmodule // test_vco_pll_divider_control_regs

`default_nettype wire
